// ==== logic/fskm_map.vh ====
// Address map, field positions, reset values and timing counts of the FSK modem core.
`ifndef FSKM_MAP_VH
`define FSKM_MAP_VH

// Register byte addresses on the AHB-Lite slave.
`define FSKM_MODE_ADDR 8'h00
`define FSKM_STATUS_ADDR 8'h04

// Mode register layout and reset value.
`define FSKM_MODE_RESET 8'h00
`define FSKM_MODE_DAC16_BIT 0
`define FSKM_MODE_CORE_DIV_LSB 1
`define FSKM_MODE_CORE_DIV_MSB 2
`define FSKM_MODE_AUX_DIV_LSB 3
`define FSKM_MODE_AUX_DIV_MSB 4
`define FSKM_MODE_KICK_INT_BIT 5
`define FSKM_MODE_NRTZ_BIT 6
`define FSKM_MODE_RX_IDLE_HIGH_BIT 7

// Divider field codes.
`define FSKM_DIV_BY2 2'b00
`define FSKM_DIV_BY4 2'b01
`define FSKM_DIV_BY1 2'b10
`define FSKM_DIV_BY4B 2'b11

// Status register layout.
`define FSKM_STAT_CARRIER_BIT 0
`define FSKM_STAT_DEMOD_BIT 1
`define FSKM_STAT_TX_MODE_BIT 2
`define FSKM_STAT_PULSES_LSB 4
`define FSKM_STAT_PULSES_MSB 6

// AHB-Lite encodings.
`define FSKM_HTRANS_NONSEQ 2'b10
`define FSKM_HRESP_OKAY 1'b0

// Tone, bit rate and internal clock figures.
`define FSKM_CORE_HZ 460800
`define FSKM_MARK_HZ 1200
`define FSKM_SPACE_HZ 2200
`define FSKM_BAUD 1200
`define FSKM_NCO_BITS 16
`define FSKM_MARK_INC ((`FSKM_MARK_HZ * 65536 + `FSKM_CORE_HZ / 2) / `FSKM_CORE_HZ)
`define FSKM_SPACE_INC ((`FSKM_SPACE_HZ * 65536 + `FSKM_CORE_HZ / 2) / `FSKM_CORE_HZ)

// Carrier qualification figures: pulse count, and timeout in microseconds and in internal clock ticks.
`define FSKM_CD_PULSES 4
`define FSKM_CD_TIMEOUT_US 2500
`define FSKM_CD_TIMEOUT_TICKS ((`FSKM_CD_TIMEOUT_US * `FSKM_CORE_HZ) / 1000000)

// Demodulator half-period figures in internal clock ticks.
`define FSKM_MARK_HALF_TICKS (`FSKM_CORE_HZ / (2 * `FSKM_MARK_HZ))
`define FSKM_SPACE_HALF_TICKS (`FSKM_CORE_HZ / (2 * `FSKM_SPACE_HZ))
`define FSKM_DEMOD_SPLIT ((`FSKM_MARK_HALF_TICKS + `FSKM_SPACE_HALF_TICKS) / 2)

`endif

// ==== logic/fskm_modem_core.v ====
// FSK line modem core: tone oscillator, demodulator, carrier qualifier and AHB-Lite registers.
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fskm_map.vh"

module fskm_modem_core #(
	parameter CD_TIMEOUT_TICKS = `FSKM_CD_TIMEOUT_TICKS
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire osc_in,
	input wire tx_data_in,
	input wire tx_request_n,
	input wire filtered_rx_comp_in,
	input wire carrier_level_in,
	output reg tone_out,
	output reg rx_bit_out,
	output reg rx_bit_out_idle_high,
	output reg carrier_present,
	output reg core_clock,
	output reg aux_clock_out
);

	// Integer figures are narrowed on purpose; every value fits its field.
	localparam integer MARK_STEP = `FSKM_MARK_INC;
	localparam integer SPACE_STEP = `FSKM_SPACE_INC;
	localparam integer PULSE_COUNT = `FSKM_CD_PULSES;
	localparam integer SPLIT_TICKS = `FSKM_DEMOD_SPLIT;
	localparam [15:0] MARK_INC = MARK_STEP[15:0];
	localparam [15:0] SPACE_INC = SPACE_STEP[15:0];
	localparam [10:0] TIMEOUT = CD_TIMEOUT_TICKS[10:0];
	localparam [2:0] CD_PULSES = PULSE_COUNT[2:0];
	localparam [7:0] DEMOD_SPLIT = SPLIT_TICKS[7:0];
	localparam [7:0] HALF_MAX = 8'hff;

	// Synchronised pins and their one-cycle-old copies for edge detection.
	wire [4:0] pins_s;
	wire osc_s;
	wire txd_s;
	wire rts_n_s;
	wire rxc_s;
	wire car_s;
	reg osc_d_reg;
	reg rxc_d_reg;
	reg car_d_reg;

	// Mode register and bus address-phase capture.
	reg [7:0] mode_reg;
	reg ap_valid_reg;
	reg ap_write_reg;
	reg [7:0] ap_addr_reg;

	// Clock dividers.
	reg [1:0] core_cnt_reg;
	reg [1:0] aux_cnt_reg;
	reg [2:0] core_half;
	reg [2:0] aux_half;
	wire src_edge;
	wire core_wrap;
	wire aux_wrap;
	wire core_tick;

	// Modulator, carrier qualifier and demodulator state.
	reg [15:0] phase_reg;
	reg [2:0] cd_cnt_reg;
	reg [2:0] cd_cnt_next;
	reg [10:0] cd_timer_reg;
	reg [10:0] cd_timer_next;
	reg carrier_next;
	reg [7:0] half_cnt_reg;
	reg demod_armed_reg;
	reg demod_bit_reg;
	wire tx_mode;
	wire rx_mode;
	wire car_pulse;
	wire rxc_edge;
	wire demod_en;

	// Bus decode and read data.
	wire bus_access;
	wire addr_mapped;
	wire mode_write;
	reg [7:0] mode_view;
	reg [31:0] rdata_next;

	// Every pin from the outside world passes two flops before use.
	// The transmit request pin idles high, so its stages reset high to start in receive mode.
	fskm_sync2 #(
		.WIDTH(5),
		.RESET_VALUE(5'h04)
	) u_pin_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({carrier_level_in, filtered_rx_comp_in, tx_request_n, tx_data_in, osc_in}),
		.q(pins_s)
	);

	assign osc_s = pins_s[0];
	assign txd_s = pins_s[1];
	assign rts_n_s = pins_s[2];
	assign rxc_s = pins_s[3];
	assign car_s = pins_s[4];

	// Delayed copies of the synchronised source clock, receive comparator and carrier level pins for edge detection.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			osc_d_reg <= 1'b0;
			rxc_d_reg <= 1'b0;
			car_d_reg <= 1'b0;
		end
		else
		begin
			osc_d_reg <= osc_s;
			rxc_d_reg <= rxc_s;
			car_d_reg <= car_s;
		end
	end

	// Number of source half-periods per divided half-period for a divider code.
	function [2:0] div_half;
		input [1:0] code;
		begin
			case (code)
				`FSKM_DIV_BY1: div_half = 3'h1;
				`FSKM_DIV_BY2: div_half = 3'h2;
				default: div_half = 3'h4;
			endcase
		end
	endfunction

	// Any source edge advances both dividers; the source may be any of three rates.
	assign src_edge = osc_s ^ osc_d_reg;
	always @*
	begin
		core_half = div_half(mode_reg[`FSKM_MODE_CORE_DIV_MSB:`FSKM_MODE_CORE_DIV_LSB]);
		aux_half = div_half(mode_reg[`FSKM_MODE_AUX_DIV_MSB:`FSKM_MODE_AUX_DIV_LSB]);
	end
	assign core_wrap = ({1'b0, core_cnt_reg} + 3'h1) >= core_half;
	assign aux_wrap = ({1'b0, aux_cnt_reg} + 3'h1) >= aux_half;

	// The core tick marks the rising edge of the divided internal clock.
	assign core_tick = src_edge & core_wrap & ~core_clock;

	// Dividers toggle their output after the selected count of source half-periods.
	// The wrap test uses >= so that a divider change mid-count cannot strand the counter.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_cnt_reg <= 2'h0;
			aux_cnt_reg <= 2'h0;
			core_clock <= 1'b0;
			aux_clock_out <= 1'b0;
		end
		else if (src_edge)
		begin
			if (core_wrap)
			begin
				core_cnt_reg <= 2'h0;
				core_clock <= ~core_clock;
			end
			else
			begin
				core_cnt_reg <= core_cnt_reg + 2'h1;
			end
			if (aux_wrap)
			begin
				aux_cnt_reg <= 2'h0;
				aux_clock_out <= ~aux_clock_out;
			end
			else
			begin
				aux_cnt_reg <= aux_cnt_reg + 2'h1;
			end
		end
	end

	assign tx_mode = ~rts_n_s;
	assign rx_mode = rts_n_s;

	// The accumulator only changes its step size at a bit change, never its phase.
	// It restarts from zero while receiving so every burst begins on the same edge.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_reg <= 16'h0000;
			tone_out <= 1'b0;
		end
		else if (!tx_mode)
		begin
			phase_reg <= 16'h0000;
			tone_out <= 1'b0;
		end
		else
		begin
			if (core_tick)
			begin
				phase_reg <= phase_reg + (txd_s ? MARK_INC : SPACE_INC);
			end
			tone_out <= phase_reg[15];
		end
	end

	assign car_pulse = car_s & ~car_d_reg;

	// Carrier qualifier: counts pulses, each reloading the timeout.
	// A pulse in the expiry cycle wins, so a late but valid pulse is never lost.
	always @*
	begin
		cd_cnt_next = cd_cnt_reg;
		cd_timer_next = cd_timer_reg;
		carrier_next = carrier_present;
		if (!rx_mode)
		begin
			cd_cnt_next = 3'h0;
			cd_timer_next = 11'h000;
			carrier_next = 1'b0;
		end
		else if (car_pulse)
		begin
			cd_timer_next = TIMEOUT;
			if (cd_cnt_reg < CD_PULSES)
			begin
				cd_cnt_next = cd_cnt_reg + 3'h1;
			end
			carrier_next = (cd_cnt_next == CD_PULSES);
		end
		else if (core_tick && (cd_timer_reg != 11'h000))
		begin
			cd_timer_next = cd_timer_reg - 11'h001;
			if (cd_timer_reg == 11'h001)
			begin
				cd_cnt_next = 3'h0;
				carrier_next = 1'b0;
			end
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cd_cnt_reg <= 3'h0;
			cd_timer_reg <= 11'h000;
			carrier_present <= 1'b0;
		end
		else
		begin
			cd_cnt_reg <= cd_cnt_next;
			cd_timer_reg <= cd_timer_next;
			carrier_present <= carrier_next;
		end
	end

	// The demodulator runs only in receive mode while carrier-level pulses are seen.
	assign demod_en = rx_mode & (carrier_present | (cd_cnt_reg != 3'h0));
	assign rxc_edge = rxc_s ^ rxc_d_reg;

	// Each zero crossing closes a half-period; a long one is mark, a short one space.
	// Deciding at every crossing keeps the data edge within one half tone period,
	// well inside the allowed jitter; the first crossing after enable only arms.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			half_cnt_reg <= 8'h00;
			demod_armed_reg <= 1'b0;
			demod_bit_reg <= 1'b1;
		end
		else if (!demod_en)
		begin
			half_cnt_reg <= 8'h00;
			demod_armed_reg <= 1'b0;
			demod_bit_reg <= 1'b1;
		end
		else if (rxc_edge)
		begin
			half_cnt_reg <= 8'h00;
			demod_armed_reg <= 1'b1;
			if (demod_armed_reg)
			begin
				demod_bit_reg <= (half_cnt_reg >= DEMOD_SPLIT);
			end
		end
		else if (core_tick && (half_cnt_reg != HALF_MAX))
		begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end

	// Receive outputs follow the demodulated bit only with a carrier present.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_bit_out <= 1'b0;
			rx_bit_out_idle_high <= 1'b1;
		end
		else if (carrier_present)
		begin
			rx_bit_out <= demod_bit_reg;
			rx_bit_out_idle_high <= demod_bit_reg;
		end
		else
		begin
			rx_bit_out <= mode_reg[`FSKM_MODE_RX_IDLE_HIGH_BIT];
			rx_bit_out_idle_high <= 1'b1;
		end
	end

	// Address phase is taken whenever the slave is selected with a non-sequential transfer while hready is high.
	assign bus_access = hsel & hready & (htrans == `FSKM_HTRANS_NONSEQ);
	assign addr_mapped = (haddr[31:3] == 29'h00000000) & (haddr[1:0] == 2'b00);
	assign mode_write = ap_valid_reg & ap_write_reg & (ap_addr_reg == `FSKM_MODE_ADDR);

	// Read data is fetched in the address phase, forwarding a write still in its data phase.
	always @*
	begin
		mode_view = mode_write ? hwdata[7:0] : mode_reg;
		rdata_next = 32'h00000000;
		if (addr_mapped && (haddr[7:0] == `FSKM_MODE_ADDR))
		begin
			rdata_next[7:0] = mode_view;
		end
		else if (addr_mapped && (haddr[7:0] == `FSKM_STATUS_ADDR))
		begin
			rdata_next[`FSKM_STAT_CARRIER_BIT] = carrier_present;
			rdata_next[`FSKM_STAT_DEMOD_BIT] = demod_bit_reg;
			rdata_next[`FSKM_STAT_TX_MODE_BIT] = tx_mode;
			rdata_next[`FSKM_STAT_PULSES_MSB:`FSKM_STAT_PULSES_LSB] = cd_cnt_reg;
		end
	end

	// Zero-wait slave: every transfer completes OKAY in its first data-phase cycle.
	// Writes to unmapped addresses are dropped and reads of them return zero.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= `FSKM_HRESP_OKAY;
			mode_reg <= `FSKM_MODE_RESET;
		end
		else
		begin
			if (hready)
			begin
				ap_valid_reg <= bus_access & addr_mapped;
				ap_write_reg <= hwrite;
				ap_addr_reg <= haddr[7:0];
			end
			if (bus_access && !hwrite)
			begin
				hrdata <= rdata_next;
			end
			if (mode_write)
			begin
				mode_reg <= hwdata[7:0];
			end
			hreadyout <= 1'b1;
			hresp <= `FSKM_HRESP_OKAY;
		end
	end

endmodule
`default_nettype wire

// ==== logic/fskm_sync2.v ====
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module fskm_sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta_reg;

	// The first stage is read by the second stage only, to contain metastability.
	// Both stages reset to the pins' idle levels, so release shows no false edge or mode.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_reg <= RESET_VALUE;
			q <= RESET_VALUE;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// ==== tb/fskm_line_peer.sv ====
// Line side model: source clock, carrier level pulses and receive comparator.
`timescale 1ns/1ps
`default_nettype none
module fskm_line_peer (
	input wire logic hclk,
	output logic osc_in,
	output logic carrier_level_in,
	output logic filtered_rx_comp_in
);
	int half = 0;
	int n_left = 0;
	// Source clock of 80 ns keeps the run short; its edges fall on hclk falling edges.
	initial osc_in = 1'b0;
	always #40 osc_in = ~osc_in;
	// Pulses every 65 cycles, well inside the shortened carrier timeout.
	initial
	begin
		carrier_level_in = 1'b0;
		forever
		begin
			@(posedge hclk);
			if (n_left > 0 || half != 0)
			begin
				carrier_level_in <= 1'b1;
				repeat (4) @(posedge hclk);
				carrier_level_in <= 1'b0;
				repeat (60) @(posedge hclk);
				if (n_left > 0)
					n_left--;
			end
		end
	end
	// The comparator flips once per zero crossing of the tone.
	initial
	begin
		filtered_rx_comp_in = 1'b0;
		forever
		begin
			@(posedge hclk);
			if (half != 0)
			begin
				repeat (half - 1) @(posedge hclk);
				filtered_rx_comp_in <= ~filtered_rx_comp_in;
			end
		end
	end
	task pulses(input int n);
		n_left = n;
		wait (n_left == 0);
	endtask
endmodule
`default_nettype wire

// ==== tb/fskm_modem_monitor.sv ====
// Port checker for the FSK modem core.
`timescale 1ns/1ps
`default_nettype none
module fskm_modem_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic tx_request_n,
	input wire logic carrier_level_in,
	input wire logic tone_out,
	input wire logic rx_bit_out,
	input wire logic rx_bit_out_idle_high,
	input wire logic carrier_present
);
	logic [8:0] quiet_reg;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Counts carrier cycles without a level pulse, since a lost timer would hold it forever.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			quiet_reg <= 9'h000;
		else if (carrier_level_in || !carrier_present)
			quiet_reg <= 9'h000;
		else
			quiet_reg <= quiet_reg + 9'h001;
	end
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus answer not ready and okay");
	property p_tx_quiet;
		tx_request_n [*5] |-> !tone_out;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet) else $error("tone in receive mode");
	property p_cd_tx;
		!tx_request_n [*5] |-> !carrier_present;
	endproperty
	a_cd_tx: assert property (p_cd_tx) else $error("carrier in transmit mode");
	property p_cd_rise;
		$rose(carrier_present) |-> $past(tx_request_n, 4);
	endproperty
	a_cd_rise: assert property (p_cd_rise) else $error("carrier rose while sending");
	property p_idle_high;
		!carrier_present [*2] |-> rx_bit_out_idle_high;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle output not high");
	property p_same;
		carrier_present [*2] |-> rx_bit_out == rx_bit_out_idle_high;
	endproperty
	a_same: assert property (p_same) else $error("receive outputs differ");
	property p_plain;
		rx_bit_out |-> rx_bit_out_idle_high;
	endproperty
	a_plain: assert property (p_plain) else $error("plain output high alone");
	property p_timeout;
		quiet_reg < 9'h0dc;
	endproperty
	a_timeout: assert property (p_timeout) else $error("carrier outlived timeout");
	c_cd_on: cover property ($rose(carrier_present));
	c_cd_off: cover property ($fell(carrier_present));
	c_tone: cover property ($rose(tone_out));
endmodule
bind fskm_modem_core fskm_modem_monitor mon_u (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.tx_request_n(tx_request_n),
	.carrier_level_in(carrier_level_in),
	.tone_out(tone_out),
	.rx_bit_out(rx_bit_out),
	.rx_bit_out_idle_high(rx_bit_out_idle_high),
	.carrier_present(carrier_present)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the FSK modem core.
`timescale 1ns/1ps
`default_nettype none
`include "fskm_map.vh"
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic tx_data_in = 1'b1;
	logic tx_request_n = 1'b1;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, osc_in, comp, level, tone_out;
	wire logic rx_bit_out, rx_bit_out_idle_high, carrier_present, core_clock, aux_clock_out;
	int n_mismatch = 0;
	int n_compared = 0;
	int dv[4] = '{2, 4, 1, 4};
	logic [31:0] r;
	int n;
	int ex;
	always #10 hclk = ~hclk;
	fskm_modem_core #(.CD_TIMEOUT_TICKS(20)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .osc_in(osc_in), .tx_data_in(tx_data_in),
		.tx_request_n(tx_request_n), .filtered_rx_comp_in(comp), .carrier_level_in(level),
		.tone_out(tone_out), .rx_bit_out(rx_bit_out),
		.rx_bit_out_idle_high(rx_bit_out_idle_high), .carrier_present(carrier_present),
		.core_clock(core_clock), .aux_clock_out(aux_clock_out));
	fskm_line_peer peer_u (.hclk(hclk), .osc_in(osc_in), .carrier_level_in(level),
		.filtered_rx_comp_in(comp));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= `FSKM_HTRANS_NONSEQ;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	// Controller character: start, eight data bits LSB first, odd parity, stop.
	// One bit lasts 384 core ticks of 8 hclk each with the /2 divider and 80 ns source.
	task send_char(input logic [7:0] c);
		logic [10:0] f;
		f = {1'b1, ~^c, c, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			tx_data_in <= f[i];
			repeat (`FSKM_CORE_HZ / `FSKM_BAUD * 8) @(posedge hclk);
		end
	endtask
	// Cycles between two rising edges of core clock, aux clock or tone.
	task per(input int k);
		logic p;
		logic s;
		int e;
		p = 1'b1;
		e = 0;
		n = 0;
		while (e < 2)
		begin
			@(posedge hclk);
			s = k == 0 ? core_clock : (k == 1 ? aux_clock_out : tone_out);
			if (s && !p)
				e++;
			if (e == 1)
				n++;
			p = s;
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// A hang counts as a mismatch.
	initial
	begin
		repeat (80000) @(posedge hclk);
		n_mismatch++;
		give_verdict;
	end
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(0, `FSKM_MODE_ADDR, 0);
		chk(r, `FSKM_MODE_RESET);
		xfer(0, `FSKM_STATUS_ADDR, 0);
		chk(r, 32'h00000002);
		xfer(1, 32'h40, 32'hff);
		xfer(0, 32'h40, 0);
		chk(r, 0);
		xfer(1, `FSKM_MODE_ADDR, 32'h80);
		xfer(0, `FSKM_MODE_ADDR, 0);
		chk(r, 32'h80);
		repeat (2) @(posedge hclk);
		chk(rx_bit_out, 1);
		xfer(1, `FSKM_MODE_ADDR, 0);
		repeat (2) @(posedge hclk);
		chk({rx_bit_out, rx_bit_out_idle_high}, 1);
		$display("test registers done");
		// The core divider is restored to /2 so later timing holds.
		for (int c = 0; c < 4; c++)
		begin
			xfer(1, `FSKM_MODE_ADDR, c * 10);
			per(0);
			per(0);
			chk(n, 4 * dv[c]);
			per(1);
			per(1);
			chk(n, 4 * dv[c]);
		end
		xfer(1, `FSKM_MODE_ADDR, 0);
		$display("test dividers done");
		tx_request_n <= 1'b0;
		// Space is measured in the start and zero data bits, mark from the parity bit on.
		fork
			send_char(8'h00);
			begin
				for (int b = 0; b < 2; b++)
				begin
					if (b)
						wait (tx_data_in === 1'b1);
					ex = `FSKM_CORE_HZ / (b ? `FSKM_MARK_HZ : `FSKM_SPACE_HZ) * 8;
					per(2);
					per(2);
					chk(n > ex - ex / 32 && n < ex + ex / 32, 1);
				end
			end
		join
		xfer(0, `FSKM_STATUS_ADDR, 0);
		chk(r[2], 1);
		tx_request_n <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(tone_out, 0);
		$display("test transmit done");
		peer_u.pulses(3);
		xfer(0, `FSKM_STATUS_ADDR, 0);
		chk(r & 32'h71, 32'h30);
		peer_u.pulses(1);
		repeat (4) @(posedge hclk);
		chk(carrier_present, 1);
		repeat (250) @(posedge hclk);
		chk(carrier_present, 0);
		peer_u.pulses(3);
		chk(carrier_present, 0);
		repeat (250) @(posedge hclk);
		$display("test carrier done");
		for (int b = 0; b < 2; b++)
		begin
			peer_u.half = b ? 1536 : 832;
			repeat (4 * peer_u.half) @(posedge hclk);
			chk({rx_bit_out, rx_bit_out_idle_high}, b ? 3 : 0);
		end
		peer_u.half = 0;
		repeat (300) @(posedge hclk);
		chk({carrier_present, rx_bit_out, rx_bit_out_idle_high}, 1);
		$display("test receive done");
		give_verdict;
	end
endmodule
`default_nettype wire
